// ==== rtl/vsc_pkg.sv ====
// Constants shared by the serial command and RAM write block
`default_nettype none
package vsc_pkg;
  localparam int BYTE_BITS = 8;
  localparam int DC_ADDR_BITS = 5;
  localparam int UG_ADDR_BITS = 4;
  localparam int UG_COLS = 5;
  localparam int DOT_ROWS = 7;
  localparam int GRID_COUNT = 24;
  localparam logic [4:0] DC_ADDR_RESET = 5'h00;
  localparam logic [3:0] UG_ADDR_RESET = 4'h0;
  localparam logic [3:0] SYM_ADDR_RESET = 4'h0;
  localparam logic [7:0] USER_CODE_LAST = 8'h0f;
  localparam logic [4:0] DC_GRID_LAST = 5'h17;
  localparam logic [2:0] BIT_CNT_RESET = 3'h0;
  localparam logic [2:0] COL_CNT_RESET = 3'h0;
  localparam logic [2:0] COL_LAST = 3'h4;
  // Command type in bits 7..5 of the first byte
  typedef enum logic [2:0] {
    VSC_CMD_DC_WRITE = 3'b001,
    VSC_CMD_UG_WRITE = 3'b010,
    VSC_CMD_SYM_WRITE = 3'b011,
    VSC_CMD_PORT = 3'b100,
    VSC_CMD_DUTY = 3'b101,
    VSC_CMD_DIGITS = 3'b110,
    VSC_CMD_LIGHTS = 3'b111,
    VSC_CMD_NONE = 3'b000
  } vsc_cmd_type;
endpackage : vsc_pkg
`default_nettype wire

// ==== rtl/vsc_serial_cmd.sv ====
// Serial command receiver with character-code and user glyph RAM writes
`default_nettype none
module vsc_serial_cmd #(
  parameter int GRIDS = vsc_pkg::GRID_COUNT
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic shift_clock_bar,
  input wire logic select_n,
  input wire logic serial_data_in,
  input wire logic [4:0] grid_index,
  output logic [7:0] grid_code,
  output logic grid_is_user,
  output logic [34:0] grid_user_dots,
  output logic grid_active,
  output logic lights_override,
  output logic [3:0] symbol_out,
  output logic [4:0] dc_addr,
  output logic [3:0] ug_addr
);
  initial begin
    if (GRIDS != 24) $error("vsc_serial_cmd supports 24 grids only");
  end

  // Link side: shift register on the shift clock
  logic [2:0] bit_cnt_q;
  logic [7:0] shreg_q;
  logic [7:0] hold_q;
  logic byte_tgl_q;
  logic first_q;
  logic hold_first_q;
  logic [7:0] shreg_d;

  assign shreg_d = {serial_data_in, shreg_q[7:1]};

  // Select high clears framing at once and keeps it clear for any link edges that arrive while it is high
  always_ff @(posedge shift_clock_bar or posedge select_n or negedge rst_n) begin
    if (!rst_n) begin
      bit_cnt_q <= vsc_pkg::BIT_CNT_RESET;
      shreg_q <= 8'h00;
      first_q <= 1'b1;
    end else if (select_n) begin
      bit_cnt_q <= vsc_pkg::BIT_CNT_RESET;
      shreg_q <= 8'h00;
      first_q <= 1'b1;
    end else begin
      shreg_q <= shreg_d;
      bit_cnt_q <= bit_cnt_q + 3'h1;
      if (bit_cnt_q == 3'h7) begin
        first_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge shift_clock_bar or negedge rst_n) begin
    if (!rst_n) begin
      hold_q <= 8'h00;
      hold_first_q <= 1'b0;
      byte_tgl_q <= 1'b0;
    end else if (bit_cnt_q == 3'h7 && !select_n) begin
      hold_q <= shreg_d;
      hold_first_q <= first_q;
      byte_tgl_q <= ~byte_tgl_q;
    end
  end

  // System side: reset release and crossing
  logic [1:0] rsync_q;
  logic srst_n;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rsync_q <= 2'b00;
    end else begin
      rsync_q <= {rsync_q[0], 1'b1};
    end
  end
  assign srst_n = rsync_q[1];

  // One toggle per byte, so no strobe is lost however the clocks line up
  logic [2:0] tgl_sync_q;
  logic load_stb;
  always_ff @(posedge clk_sys or negedge srst_n) begin
    if (!srst_n) begin
      tgl_sync_q <= 3'h0;
    end else begin
      tgl_sync_q <= {tgl_sync_q[1:0], byte_tgl_q};
    end
  end
  // Held byte is stable for a whole byte time, far longer than the sync delay
  assign load_stb = tgl_sync_q[2] ^ tgl_sync_q[1];

  // Command decode and RAM writes
  vsc_pkg::vsc_cmd_type cmd_q;
  logic [2:0] col_q;
  logic [3:0] sym_addr_q;
  logic [7:0] char_code_ram [32];
  logic [34:0] user_glyph_ram [16];
  logic [3:0] symbol_ram [32];
  logic [27:0] cols_q;
  logic [6:0] col_bits;
  assign col_bits = hold_q[6:0];
  // Data byte strobes, one per RAM write command
  logic data_stb;
  logic dc_wr;
  logic ug_wr;
  logic sym_wr;
  assign data_stb = load_stb && !hold_first_q;
  assign dc_wr = data_stb && cmd_q == vsc_pkg::VSC_CMD_DC_WRITE;
  assign ug_wr = data_stb && cmd_q == vsc_pkg::VSC_CMD_UG_WRITE;
  assign sym_wr = data_stb && cmd_q == vsc_pkg::VSC_CMD_SYM_WRITE;

  function automatic logic is_ram_cmd(input logic [2:0] c);
    return c == vsc_pkg::VSC_CMD_DC_WRITE || c == vsc_pkg::VSC_CMD_UG_WRITE ||
           c == vsc_pkg::VSC_CMD_SYM_WRITE;
  endfunction : is_ram_cmd

  always_ff @(posedge clk_sys or negedge srst_n) begin
    if (!srst_n) begin
      cmd_q <= vsc_pkg::VSC_CMD_NONE;
      dc_addr <= vsc_pkg::DC_ADDR_RESET;
      ug_addr <= vsc_pkg::UG_ADDR_RESET;
      sym_addr_q <= vsc_pkg::SYM_ADDR_RESET;
      col_q <= vsc_pkg::COL_CNT_RESET;
      lights_override <= 1'b0;
    end else if (load_stb) begin
      if (hold_first_q) begin
        cmd_q <= vsc_pkg::vsc_cmd_type'(hold_q[7:5]);
        col_q <= vsc_pkg::COL_CNT_RESET;
        unique case (vsc_pkg::vsc_cmd_type'(hold_q[7:5]))
          vsc_pkg::VSC_CMD_DC_WRITE: dc_addr <= hold_q[4:0];
          vsc_pkg::VSC_CMD_UG_WRITE: ug_addr <= hold_q[3:0];
          vsc_pkg::VSC_CMD_SYM_WRITE: sym_addr_q <= hold_q[3:0];
          vsc_pkg::VSC_CMD_LIGHTS: begin
            if (hold_q[1:0] == 2'b01) begin
              lights_override <= 1'b1;
            end else if (hold_q[1:0] == 2'b10) begin
              lights_override <= 1'b0;
            end
          end
          default: begin
          end
        endcase
      end else if (is_ram_cmd(cmd_q)) begin
        unique case (cmd_q)
          vsc_pkg::VSC_CMD_DC_WRITE: dc_addr <= dc_addr + 5'h01;
          vsc_pkg::VSC_CMD_SYM_WRITE: sym_addr_q <= sym_addr_q + 4'h1;
          default: begin
            if (col_q == vsc_pkg::COL_LAST) begin
              col_q <= vsc_pkg::COL_CNT_RESET;
              ug_addr <= ug_addr + 4'h1;
            end else begin
              col_q <= col_q + 3'h1;
            end
          end
        endcase
      end
    end
  end

  // RAM arrays: no reset, contents undefined after reset
  always_ff @(posedge clk_sys) begin
    if (dc_wr) begin
      char_code_ram[dc_addr] <= hold_q;
    end
    if (sym_wr) begin
      symbol_ram[{1'b0, sym_addr_q}] <= hold_q[3:0];
    end
    if (ug_wr) begin
      if (col_q == vsc_pkg::COL_LAST) begin
        user_glyph_ram[ug_addr] <= {col_bits, cols_q};
      end else begin
        cols_q <= {col_bits, cols_q[27:7]};
      end
    end
  end

  // Unwritten symbol entries read as low, so segments stay dark after reset
  logic [31:0] sym_set_q;
  always_ff @(posedge clk_sys or negedge srst_n) begin
    if (!srst_n) begin
      sym_set_q <= 32'h00000000;
    end else if (sym_wr) begin
      sym_set_q[{1'b0, sym_addr_q}] <= 1'b1;
    end
  end

  // Read side for the display scanner
  logic [7:0] rd_code;
  assign rd_code = char_code_ram[grid_index];
  always_ff @(posedge clk_sys or negedge srst_n) begin
    if (!srst_n) begin
      grid_code <= 8'h00;
      grid_is_user <= 1'b0;
      grid_user_dots <= 35'h0;
      grid_active <= 1'b0;
      symbol_out <= 4'h0;
    end else begin
      grid_code <= rd_code;
      grid_is_user <= rd_code <= vsc_pkg::USER_CODE_LAST;
      grid_user_dots <= user_glyph_ram[rd_code[3:0]];
      grid_active <= grid_index <= vsc_pkg::DC_GRID_LAST;
      symbol_out <= sym_set_q[grid_index] ? symbol_ram[grid_index] : 4'h0;
    end
  end

  // Assertions
  addr_reset_a: assert property (@(posedge clk_sys) $rose(srst_n) |-> dc_addr == 5'h00)
    else $error("char address not zero after reset");
  lights_reset_a: assert property (@(posedge clk_sys) $rose(srst_n) |-> !lights_override)
    else $error("lights override on after reset");
  sym_reset_a: assert property (@(posedge clk_sys) $rose(srst_n) |-> symbol_out == 4'h0)
    else $error("symbol outputs not low after reset");
  sym_low_a: assert property (@(posedge clk_sys) disable iff (!srst_n)
    !sym_set_q[grid_index] |=> symbol_out == 4'h0)
    else $error("unwritten symbol entry not low");

  dc_inc_a: assert property (@(posedge clk_sys) disable iff (!srst_n)
    dc_wr |=> dc_addr == $past(dc_addr) + 5'h01)
    else $error("char address did not advance");
  dc_load_a: assert property (@(posedge clk_sys) disable iff (!srst_n)
    load_stb && hold_first_q && hold_q[7:5] == vsc_pkg::VSC_CMD_DC_WRITE
    |=> dc_addr == $past(hold_q[4:0]))
    else $error("char address not loaded from command");
  dc_hold_a: assert property (@(posedge clk_sys) disable iff (!srst_n)
    !load_stb |=> $stable(dc_addr))
    else $error("char address moved without a byte");
  ug_adv_a: assert property (@(posedge clk_sys) disable iff (!srst_n)
    ug_wr && col_q != vsc_pkg::COL_LAST |=> ug_addr == $past(ug_addr))
    else $error("glyph address moved mid pattern");
  ug_step_a: assert property (@(posedge clk_sys) disable iff (!srst_n)
    ug_wr && col_q == vsc_pkg::COL_LAST |=> ug_addr == $past(ug_addr) + 4'h1)
    else $error("glyph address did not advance after pattern");
  ug_load_a: assert property (@(posedge clk_sys) disable iff (!srst_n)
    load_stb && hold_first_q && hold_q[7:5] == vsc_pkg::VSC_CMD_UG_WRITE
    |=> ug_addr == $past(hold_q[3:0]))
    else $error("glyph address not loaded from command");
  ug_hold_a: assert property (@(posedge clk_sys) disable iff (!srst_n)
    !load_stb |=> $stable(ug_addr))
    else $error("glyph address moved without a byte");
  col_step_a: assert property (@(posedge clk_sys) disable iff (!srst_n)
    ug_wr && col_q != vsc_pkg::COL_LAST |=> col_q == $past(col_q) + 3'h1)
    else $error("pattern column did not advance");
  col_start_a: assert property (@(posedge clk_sys) disable iff (!srst_n)
    load_stb && hold_first_q |=> col_q == vsc_pkg::COL_CNT_RESET)
    else $error("pattern column not restarted by command");
  sym_step_a: assert property (@(posedge clk_sys) disable iff (!srst_n)
    sym_wr |=> sym_addr_q == $past(sym_addr_q) + 4'h1)
    else $error("symbol address did not advance");
  user_sel_a: assert property (@(posedge clk_sys) disable iff (!srst_n)
    grid_is_user |-> grid_code[7:4] == 4'h0)
    else $error("user glyph flagged for ROM code");
  grid_map_a: assert property (@(posedge clk_sys) disable iff (!srst_n)
    grid_active |-> $past(grid_index) < 5'h18)
    else $error("grid active on unmapped address");
  cmd_dec_a: assert property (@(posedge clk_sys) disable iff (!srst_n)
    load_stb && hold_first_q |=> cmd_q == vsc_pkg::vsc_cmd_type'($past(hold_q[7:5])))
    else $error("command type not latched");
  lights_on_a: assert property (@(posedge clk_sys) disable iff (!srst_n)
    load_stb && hold_first_q && hold_q[7:5] == vsc_pkg::VSC_CMD_LIGHTS && hold_q[1:0] == 2'b01
    |=> lights_override)
    else $error("lights override not switched on");
  lights_off_a: assert property (@(posedge clk_sys) disable iff (!srst_n)
    load_stb && hold_first_q && hold_q[7:5] == vsc_pkg::VSC_CMD_LIGHTS && hold_q[1:0] == 2'b10
    |=> !lights_override)
    else $error("lights override not switched off");
  stb_pulse_a: assert property (@(posedge clk_sys) disable iff (!srst_n)
    load_stb |=> !load_stb)
    else $error("load strobe longer than one cycle");

  // Link side checks run on the link's own edges
  idle_clear_a: assert property (@(posedge shift_clock_bar) disable iff (!rst_n)
    select_n |-> bit_cnt_q == vsc_pkg::BIT_CNT_RESET)
    else $error("bit count moved with select high");
  frame_start_a: assert property (@(negedge select_n) disable iff (!rst_n)
    bit_cnt_q == vsc_pkg::BIT_CNT_RESET)
    else $error("framing not restarted at select fall");

  // Main scenarios
  dc_wrap_c: cover property (@(posedge clk_sys) dc_addr == 5'h1f ##[1:1000] dc_addr == 5'h00);
  ug_adv_c: cover property (@(posedge clk_sys)
    $changed(ug_addr) && cmd_q == vsc_pkg::VSC_CMD_UG_WRITE);
  lights_c: cover property (@(posedge clk_sys) $rose(lights_override));
  glyph_done_c: cover property (@(posedge clk_sys) ug_wr && col_q == vsc_pkg::COL_LAST);
  sym_wr_c: cover property (@(posedge clk_sys) sym_wr);
endmodule : vsc_serial_cmd
`default_nettype wire

// ==== verif/testbench.sv ====
// Self-checking bench for the serial command and RAM write block
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic shift_clock_bar, select_n, serial_data_in;
  logic [4:0] grid_index = 5'h00;
  logic [7:0] grid_code;
  logic grid_is_user, grid_active, lights_override;
  logic [34:0] grid_user_dots;
  logic [3:0] symbol_out, ug_addr;
  logic [4:0] dc_addr, a;
  logic [7:0] b;
  logic [3:0] g;
  logic [7:0] dc_mem [32];
  logic [34:0] ug_mem [16];
  logic [3:0] sym_mem [32];
  int error_cnt = 0;
  int n_checks = 0;
  int cyc = 0;
  int seed = 32'h8091f791;
  always #12.5 clk_sys = ~clk_sys;
  vsc_host_model host (.shift_clock_bar(shift_clock_bar), .select_n(select_n),
    .serial_data_in(serial_data_in));
  vsc_serial_cmd uut (.clk_sys(clk_sys), .rst_n(rst_n), .shift_clock_bar(shift_clock_bar),
    .select_n(select_n), .serial_data_in(serial_data_in), .grid_index(grid_index),
    .grid_code(grid_code), .grid_is_user(grid_is_user), .grid_user_dots(grid_user_dots),
    .grid_active(grid_active), .lights_override(lights_override), .symbol_out(symbol_out),
    .dc_addr(dc_addr), .ug_addr(ug_addr));
  function automatic logic exp_user(input logic [7:0] c);
    return c <= 8'h0f;
  endfunction : exp_user
  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic give_verdict();
    $display("Checks %0d, mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : give_verdict
  task automatic do_reset();
    @(negedge clk_sys) rst_n = 1'b0;
    repeat (5) @(negedge clk_sys);
    check("lights_override", lights_override, 1'b0);
    check("symbol_out", symbol_out, 4'h0);
    rst_n = 1'b1;
    repeat (3) @(negedge clk_sys);
    check("dc_addr", dc_addr, 5'h00);
    check("ug_addr", ug_addr, 4'h0);
    check("symbol_out", symbol_out, 4'h0);
  endtask : do_reset
  task automatic send_frame(input logic [7:0] cmd);
    host.open_frame();
    host.send_bits(cmd, 8);
  endtask : send_frame
  task automatic glyph_write(input logic [3:0] start);
    send_frame({4'b0100, start});
    g = start;
    for (int i = 0; i < 80; i++) begin
      b = $random(seed);
      host.send_bits(b, 8);
      ug_mem[g][7*(i%5) +: 7] = b[6:0];
      if (i % 5 == 4) g = g + 4'h1;
      check("ug_addr", ug_addr, g);
    end
    host.close_frame();
  endtask : glyph_write
  task automatic char_write(input logic [4:0] start, input int n);
    send_frame({3'b001, start});
    a = start;
    for (int i = 0; i < n; i++) begin
      b = (i == 0) ? 8'h0f : (i == 1) ? 8'h10 : 8'($random(seed));
      host.send_bits(b, 8);
      dc_mem[a] = b;
      a = a + 5'h01;
      check("dc_addr", dc_addr, a);
    end
    host.close_frame();
  endtask : char_write
  task automatic read_grid(input logic [4:0] idx);
    @(negedge clk_sys) grid_index = idx;
    repeat (2) @(negedge clk_sys);
    check("grid_code", grid_code, dc_mem[idx]);
    check("grid_is_user", grid_is_user, exp_user(dc_mem[idx]));
    check("grid_active", grid_active, idx <= 5'h17);
    check("symbol_out", symbol_out, sym_mem[idx]);
    if (exp_user(dc_mem[idx])) begin
      check("grid_user_dots", grid_user_dots, ug_mem[dc_mem[idx][3:0]]);
    end
  endtask : read_grid
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 6000) begin
      error_cnt++;
      give_verdict();
    end
  end
  initial begin
    for (int i = 0; i < 32; i++) sym_mem[i] = 4'h0;
    do_reset();
    host.send_bits(8'he1, 8);
    check("lights_override", lights_override, 1'b0);
    glyph_write(4'($random(seed)));
    char_write(5'h1e, 32);
    // Symbol writes land in entries 2..4, the rest must read low
    send_frame({3'b011, 5'h02});
    for (int i = 0; i < 3; i++) begin
      b = 8'($random(seed));
      host.send_bits(b, 8);
      sym_mem[5'h02 + i] = b[3:0];
    end
    host.close_frame();
    for (int i = 0; i < 32; i++) read_grid(i[4:0]);
    // Torn byte must not shift later framing
    host.open_frame();
    host.send_bits(8'hff, 3);
    host.close_frame();
    char_write(5'h03, 2);
    read_grid(5'h03);
    send_frame(8'he1);
    check("lights_override", lights_override, 1'b1);
    host.send_bits(8'he2, 8);
    check("lights_override", lights_override, 1'b1);
    host.close_frame();
    send_frame(8'he2);
    host.close_frame();
    check("lights_override", lights_override, 1'b0);
    // Override left on so the mid-run reset has something to clear
    send_frame(8'he1);
    host.close_frame();
    check("lights_override", lights_override, 1'b1);
    do_reset();
    send_frame(8'he2);
    host.close_frame();
    check("lights_override", lights_override, 1'b0);
    give_verdict();
  end
endmodule : testbench
`default_nettype wire

// ==== verif/vsc_host_model.sv ====
// Host model driving the three-wire serial link
`default_nettype none
module vsc_host_model (
  output logic shift_clock_bar,
  output logic select_n,
  output logic serial_data_in
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    shift_clock_bar = 1'b1;
    select_n = 1'b1;
    serial_data_in = 1'b0;
  end
  task automatic open_frame();
    select_n = 1'b0;
    #250;
  endtask : open_frame
  // Clock runs only inside bytes; data flips once hold is over
  task automatic send_bits(input logic [7:0] b, input int n);
    for (int i = 0; i < n; i++) begin
      shift_clock_bar = 1'b0;
      serial_data_in = b[i];
      #3 shift_clock_bar = 1'b1;
      #3;
    end
    serial_data_in = ~serial_data_in;
    #300;
  endtask : send_bits
  task automatic close_frame();
    select_n = 1'b1;
    serial_data_in = ~serial_data_in;
    #250;
  endtask : close_frame
endmodule : vsc_host_model
`default_nettype wire
